// File: rtl/pkg_pkg.sv
// Package of constants and types for the port line block with keyboard interrupts.
package pkg_pkg;
  localparam int PKG_LINES = 8;
  localparam logic [7:0] PKG_OFS_DATA = 8'h00;
  localparam logic [7:0] PKG_OFS_DIR = 8'h04;
  localparam logic [7:0] PKG_OFS_CFG = 8'h20;
  localparam logic [7:0] PKG_OFS_STAT = 8'h24;
  localparam logic [7:0] PKG_DIR_RST = 8'h00;
  localparam logic [7:0] PKG_CFG_RST = 8'h00;
  localparam logic [7:0] PKG_STAT_RST = 8'h00;
  localparam logic [1:0] PKG_RESP_OKAY = 2'h0;
  localparam logic [1:0] PKG_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic high_ref_route_en;
    logic upper_pullup_off;
    logic upper_edge_select;
    logic upper_irq_en;
    logic lower_pullup_off;
    logic lower_edge_select;
    logic lower_irq_en;
    logic low_ref_route_en;
  } pkg_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } pkg_pins_t;

  typedef struct packed {
    logic converter_high_ref;
    logic converter_low_ref;
  } pkg_ref_t;
endpackage : pkg_pkg

// File: rtl/pkg_edge_flags.sv
// Synchroniser, edge detector and sticky interrupt flags for the port lines.
`timescale 1ns/1ps
module pkg_edge_flags #(
  parameter int LINES = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [LINES-1:0] pin_in,
  input wire logic [LINES-1:0] edge_rise,
  input wire logic [LINES-1:0] line_en,
  input wire logic [LINES-1:0] clear_mask,
  output logic [LINES-1:0] pin_sync,
  output logic [LINES-1:0] flags
);
  import pkg_pkg::*;
  logic [LINES-1:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d, flag_q, flag_d;
  logic [LINES-1:0] hit;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
    for (int i = 0; i < LINES; i++) begin
      hit[i] = line_en[i] && (edge_rise[i] ? (sync_q[i] && !prev_q[i]) : (!sync_q[i] && prev_q[i]));
      flag_d[i] = hit[i] | (flag_q[i] & ~clear_mask[i]);
    end
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
    if (!rstn) begin
      prev_q <= '0;
      flag_q <= LINES'(PKG_STAT_RST);
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  assign pin_sync = sync_q;
  assign flags = flag_q;

  a_flag_sets_on_edge: assert property (@(posedge clk) disable iff (!rstn) hit[0] |=> flag_q[0])
    else $error("Edge on line 0 did not set its flag.");
  a_flag_clears: assert property (@(posedge clk) disable iff (!rstn)
    (clear_mask[1] && !hit[1]) |=> !flag_q[1])
    else $error("Flag 1 not cleared by a write of one.");
  a_no_spurious_flag: assert property (@(posedge clk) disable iff (!rstn)
    (!flag_q[2] && !hit[2]) |=> !flag_q[2])
    else $error("Flag 2 set without a qualifying edge.");
endmodule : pkg_edge_flags

// File: rtl/pkg_port_top.sv
// Eight-line port with direction, latches, pull-ups, reference routing and keyboard flags over AXI4-Lite.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pkg_port_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_lines_in,
  output pkg_pkg::pkg_pins_t port_lines,
  input wire logic cpu_irq_mask,
  output logic kbd_irq_raw,
  output logic kbd_irq_req,
  input wire logic converter_high_in,
  input wire logic converter_low_in,
  output pkg_pkg::pkg_ref_t converter_refs,
  output logic high_ref_route_en,
  output logic low_ref_route_en
);
  import pkg_pkg::*;

  logic [7:0] data_q, data_d, dir_q, dir_d;
  pkg_cfg_t cfg_q, cfg_d;
  logic [7:0] aw_q, aw_d, wd_q, wd_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, we_q, we_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] clear_mask, pin_sync, flags, edge_rise, line_en;
  logic wr_go, rd_go;

  function automatic logic known_ofs(input logic [7:0] a);
    return (a == PKG_OFS_DATA) || (a == PKG_OFS_DIR) || (a == PKG_OFS_CFG) || (a == PKG_OFS_STAT);
  endfunction : known_ofs

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb begin
    aw_d = aw_q;
    wd_d = wd_q;
    we_d = we_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    data_d = data_q;
    dir_d = dir_q;
    cfg_d = cfg_q;
    clear_mask = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_d = s_axi_wdata[7:0];
      we_d = s_axi_wstrb[0];
      w_have_d = 1'b1;
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = known_ofs(aw_q) ? PKG_RESP_OKAY : PKG_RESP_SLVERR;
      if (we_q) begin
        unique case (aw_q)
          PKG_OFS_DATA: data_d = wd_q;
          PKG_OFS_DIR: dir_d = wd_q;
          PKG_OFS_CFG: cfg_d = pkg_cfg_t'(wd_q);
          PKG_OFS_STAT: clear_mask = wd_q;
          default: ;
        endcase
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = known_ofs(s_axi_araddr) ? PKG_RESP_OKAY : PKG_RESP_SLVERR;
      unique case (s_axi_araddr)
        PKG_OFS_DATA: rdata_d = {24'h000000, (dir_q & data_q) | (~dir_q & pin_sync)};
        PKG_OFS_DIR: rdata_d = {24'h000000, dir_q};
        PKG_OFS_CFG: rdata_d = {24'h000000, cfg_q};
        PKG_OFS_STAT: rdata_d = {24'h000000, flags};
        default: rdata_d = 32'h00000000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    data_q <= data_d;
    aw_q <= aw_d;
    wd_q <= wd_d;
    we_q <= we_d;
    rdata_q <= rdata_d;
    bresp_q <= bresp_d;
    rresp_q <= rresp_d;
    if (!rstn) begin
      dir_q <= PKG_DIR_RST;
      cfg_q <= pkg_cfg_t'(PKG_CFG_RST);
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
      cfg_q <= cfg_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  assign edge_rise = {{4{cfg_q.upper_edge_select}}, {4{cfg_q.lower_edge_select}}};
  assign line_en = {{4{cfg_q.upper_irq_en}}, {4{cfg_q.lower_irq_en}}};

  pkg_edge_flags #(
    .LINES(PKG_LINES)
  ) u_flags (
    .clk(clk),
    .rstn(rstn),
    .pin_in(port_lines_in),
    .edge_rise(edge_rise),
    .line_en(line_en),
    .clear_mask(clear_mask),
    .pin_sync(pin_sync),
    .flags(flags)
  );

  assign port_lines.out = data_q;
  assign port_lines.oe = dir_q;
  assign port_lines.pullup_en = ~dir_q & {{4{~cfg_q.upper_pullup_off}}, {4{~cfg_q.lower_pullup_off}}};
  assign kbd_irq_raw = |flags;
  assign kbd_irq_req = kbd_irq_raw && !cpu_irq_mask;
  assign high_ref_route_en = cfg_q.high_ref_route_en;
  assign low_ref_route_en = cfg_q.low_ref_route_en;
  // The internal supply is a constant one and internal ground a constant zero on the reference paths.
  assign converter_refs.converter_high_ref = cfg_q.high_ref_route_en ? converter_high_in : 1'b1;
  assign converter_refs.converter_low_ref = cfg_q.low_ref_route_en ? converter_low_in : 1'b0;

  a_dir_reset_clear: assert property (@(posedge clk) !rstn |=> (dir_q == 8'h00 && cfg_q == 8'h00))
    else $error("Reset did not clear direction and configuration.");
  a_output_drive: assert property (@(posedge clk) disable iff (!rstn)
    (port_lines.oe == dir_q) && ((port_lines.out & dir_q) == (data_q & dir_q)))
    else $error("Output drive does not follow latch and direction.");
  a_pullup_off_out: assert property (@(posedge clk) disable iff (!rstn) (port_lines.pullup_en & dir_q) == 8'h00)
    else $error("Pull-up on while line drives.");
  a_irq_or_flags: assert property (@(posedge clk) disable iff (!rstn)
    kbd_irq_req == ((flags != 8'h00) && !cpu_irq_mask))
    else $error("Interrupt request not the masked OR of flags.");
  a_data_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && we_q && aw_q == PKG_OFS_DATA) |=> data_q == $past(wd_q))
    else $error("Data write did not update the latch.");
  a_data_read: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && s_axi_araddr == PKG_OFS_DATA) |=> rdata_q[7:0] == (($past(dir_q) & $past(data_q)) | (~$past(dir_q) & $past(pin_sync))))
    else $error("Data read mixes latch and pin wrongly.");
  a_cfg_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && we_q && aw_q == PKG_OFS_CFG) |=> cfg_q == $past(wd_q))
    else $error("Configuration write lost.");
  a_upper_pullup: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.upper_pullup_off) |-> port_lines.pullup_en[7:4] == 4'h0)
    else $error("Upper pull-ups not off.");
  a_ref_route: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_q.low_ref_route_en |-> !converter_refs.converter_low_ref)
    else $error("Low reference not internal ground.");

  sequence s_bresp_waiting;
    bvalid_q && !s_axi_bready;
  endsequence
  sequence s_rdata_waiting;
    rvalid_q && !s_axi_rready;
  endsequence
  sequence s_dir_written;
    wr_go && we_q && (aw_q == PKG_OFS_DIR);
  endsequence

  a_bresp_holds: assert property (@(posedge clk) disable iff (!rstn)
    s_bresp_waiting |=> bvalid_q && $stable(bresp_q))
    else $error("Write response dropped before it was taken.");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rstn)
    s_rdata_waiting |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("Read data changed before it was taken.");
  a_dir_write: assert property (@(posedge clk) disable iff (!rstn)
    s_dir_written |=> dir_q == $past(wd_q))
    else $error("Direction write did not land.");
  a_unmapped_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && !known_ofs(aw_q)) |=> (bresp_q == PKG_RESP_SLVERR) && (dir_q == $past(dir_q)) && (cfg_q == $past(cfg_q)))
    else $error("Write to an unmapped offset was not refused.");
  a_dir_read: assert property (@(posedge clk) disable iff (!rstn)
    (rd_go && s_axi_araddr == PKG_OFS_DIR) |=> rdata_q == {24'h000000, $past(dir_q)})
    else $error("Direction read returned the wrong value.");
endmodule : pkg_port_top

// File: test/pkg_cpu_model.sv
// Register bus master standing in for the CPU core.
`timescale 1ns/1ps
module pkg_cpu_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  // Released payloads show the inverse so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] t;
    t = 2'b00;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(bvalid && t == 2'b11)) begin
      @(posedge clk);
      if (awready && !t[0]) begin
        t[0] = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready && !t[1]) begin
        t[1] = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
        wstrb <= ~s;
      end
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic t;
    t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!(rvalid && t)) begin
      @(posedge clk);
      if (arready && !t) begin
        t = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    rready <= 1'b0;
  endtask : rd
endmodule : pkg_cpu_model

// File: test/test_pkg_port_top.sv
// Self-checking bench for the eight-line port block.
`timescale 1ns/1ps
module test_pkg_port_top;
  import pkg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, mask_q = 1'b0, hi_in = 1'b0, lo_in = 1'b1;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic irq_raw, irq_req, hr_en, lr_en;
  logic [7:0] ext_q = 8'h00, awaddr, araddr, lines_in, d, m, p, c, ln;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  pkg_pins_t pins;
  pkg_ref_t refs;
  logic [33:0] rq[$], bq[$];
  int mismatches = 0, num_checks = 0;
  always #50 clk = ~clk;
  assign lines_in = (pins.oe & pins.out) | (~pins.oe & ext_q);
  pkg_port_top DUT (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_lines_in(lines_in),
    .port_lines(pins), .cpu_irq_mask(mask_q), .kbd_irq_raw(irq_raw), .kbd_irq_req(irq_req),
    .converter_high_in(hi_in), .converter_low_in(lo_in), .converter_refs(refs),
    .high_ref_route_en(hr_en), .low_ref_route_en(lr_en));
  pkg_cpu_model u_cpu (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, bq.pop_front());
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
    rq.push_back({r, 24'h0, e});
    u_cpu.rd(a);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    bq.push_back({r, 32'h0});
    u_cpu.wr(a, {24'h0, v}, 4'hF);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick
  task automatic pin(input logic [7:0] v);
    @(posedge clk);
    ext_q <= v;
  endtask : pin
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h10060318));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(PKG_OFS_DIR, PKG_DIR_RST, PKG_RESP_OKAY);
    rd(PKG_OFS_CFG, PKG_CFG_RST, PKG_RESP_OKAY);
    rd(PKG_OFS_STAT, PKG_STAT_RST, PKG_RESP_OKAY);
    rd(8'h08, 8'h00, PKG_RESP_SLVERR);
    wr(8'h08, 8'h5A, PKG_RESP_SLVERR);
    d = 8'($urandom);
    p = 8'($urandom);
    m = 8'($urandom);
    wr(PKG_OFS_DATA, d, PKG_RESP_OKAY);
    pin(p);
    tick(3);
    chk(pins.oe, 8'h00);
    chk(pins.out, d);
    rd(PKG_OFS_DATA, p, PKG_RESP_OKAY);
    wr(PKG_OFS_DIR, m, PKG_RESP_OKAY);
    rd(PKG_OFS_DIR, m, PKG_RESP_OKAY);
    tick(3);
    chk(pins.oe, m);
    rd(PKG_OFS_DATA, (d & m) | (p & ~m), PKG_RESP_OKAY);
    d = ~((d & m) | (p & ~m));
    wr(PKG_OFS_DATA, d, PKG_RESP_OKAY);
    tick(0);
    chk(pins.out, d);
    bq.push_back({PKG_RESP_OKAY, 32'h0});
    u_cpu.wr(PKG_OFS_DIR, {24'h0, ~m}, 4'hE);
    rd(PKG_OFS_DIR, m, PKG_RESP_OKAY);
    m = m & 8'h7E;
    wr(PKG_OFS_DIR, m, PKG_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      c = {i[0], i[1], 2'b00, i[0], 2'b00, i[1]};
      wr(PKG_OFS_CFG, c, PKG_RESP_OKAY);
      rd(PKG_OFS_CFG, c, PKG_RESP_OKAY);
      tick(0);
      chk(pins.pullup_en, ~m & {{4{~c[6]}}, {4{~c[3]}}});
      chk({refs, hr_en, lr_en}, {c[7] ? hi_in : 1'b1, c[0] ? lo_in : 1'b0, c[7], c[0]});
    end
    wr(PKG_OFS_DIR, 8'h00, PKG_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      ln = k[1] ? 8'hF0 : 8'h0F;
      c = k[1] ? {2'b00, k[0], 1'b1, 4'h0} : {5'h00, k[0], 1'b1, 1'b0};
      wr(PKG_OFS_CFG, k[1] ? 8'h02 : 8'h10, PKG_RESP_OKAY);
      pin(k[0] ? 8'h00 : 8'hFF);
      tick(4);
      wr(PKG_OFS_STAT, 8'hFF, PKG_RESP_OKAY);
      pin(ext_q ^ ln);
      tick(4);
      pin(ext_q ^ ln);
      tick(4);
      chk(irq_raw, 1'b0);
      wr(PKG_OFS_CFG, c, PKG_RESP_OKAY);
      pin(ext_q ^ ln);
      tick(4);
      chk(irq_raw, 1'b1);
      rd(PKG_OFS_STAT, ln, PKG_RESP_OKAY);
      @(posedge clk);
      mask_q <= 1'b1;
      tick(0);
      chk(irq_req, 1'b0);
      @(posedge clk);
      mask_q <= 1'b0;
      tick(0);
      chk(irq_req, 1'b1);
      wr(PKG_OFS_STAT, 8'h55, PKG_RESP_OKAY);
      rd(PKG_OFS_STAT, ln & 8'hAA, PKG_RESP_OKAY);
      pin(ext_q ^ ln);
      tick(4);
      rd(PKG_OFS_STAT, ln & 8'hAA, PKG_RESP_OKAY);
      wr(PKG_OFS_STAT, 8'hFF, PKG_RESP_OKAY);
      tick(0);
      chk(irq_raw, 1'b0);
    end
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    tick(0);
    chk(pins.oe, PKG_DIR_RST);
    chk(pins.out, d);
    rd(PKG_OFS_CFG, PKG_CFG_RST, PKG_RESP_OKAY);
    tick(2);
    give_verdict();
  end
endmodule : test_pkg_port_top
